/* core/pt_device_end.sv */
`timescale 1ns/1ps
// Behaviour
// - last digit of method: 0 abs, 1 inc
// - abs: set-point rise when stopped starts
// - set-point rise while rotating is ignored
// - inc: direction bit chosen before set-point
// - inc: direction bit on reverses rotation
// - chain consecutive entries while aux continues
// - abs: aux 1 absolute, 3 incremental, chained
// - abs: aux 0 or 2 ends the chain
// - abs: absolute-entry target behind reverses direction
// - inc: travel is sum of entry data
// - inc: aux 1 chains, aux 0 ends
module pt_device_end
    import pt_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    pt_link_if.device link,
    input wire logic [3:0] command_method_parameter,
    input wire logic servo_ready,
    input wire logic [IDX_W-1:0] start_index,
    input wire logic [POS_W-1:0] current_pos,
    input wire logic motion_done,
    output logic [IDX_W-1:0] table_index,
    input wire logic [POS_W-1:0] table_pos,
    input wire logic [DWELL_W-1:0] table_dwell,
    input wire logic [1:0] table_aux,
    output logic move_start,
    output logic [POS_W-1:0] move_target,
    output logic move_reverse,
    output logic [POS_W-1:0] travel_total
);
    seq_state_t state_q, state_d;
    logic [IDX_W-1:0] idx_q, idx_d;
    logic [POS_W-1:0] tgt_q, tgt_d;
    logic [POS_W-1:0] sum_q, sum_d;
    logic rev_q, rev_d;
    logic dir_q, dir_d;
    logic inc_q, inc_d;
    logic go_q, go_d;
    logic last_q, last_d;
    logic done_q, done_d;
    logic [DWELL_W-1:0] dw_q, dw_d;
    logic [DWELL_W-1:0] dwell_q, dwell_d;
    logic [CYC_W-1:0] cyc_q, cyc_d;
    logic sp_q;
    logic sp_rise;
    logic entry_abs;
    logic entry_end;

    assign sp_rise = link.control_word[CW_SETPOINT_BIT] && !sp_q;

    // ------------------------------------------------------------
    // entry decode
    // ------------------------------------------------------------
    always_comb begin
        if (inc_q) begin
            entry_abs = 1'b0;
            entry_end = (table_aux == AUX_ABS_END);
        end else begin
            entry_abs = (table_aux == AUX_ABS_END) ||
                (table_aux == AUX_ABS_CHAIN);
            entry_end = (table_aux == AUX_ABS_END) ||
                (table_aux == AUX_INC_END);
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        tgt_d = tgt_q;
        sum_d = sum_q;
        rev_d = rev_q;
        dir_d = dir_q;
        inc_d = inc_q;
        go_d = 1'b0;
        last_d = last_q;
        done_d = 1'b0;
        dw_d = dw_q;
        dwell_d = dwell_q;
        cyc_d = cyc_q;
        case (state_q)
            S_IDLE: begin
                // a rise while moving is dropped, not deferred
                if (sp_rise && servo_ready && !motion_done) begin
                    state_d = S_IDLE;
                end else if (sp_rise && servo_ready) begin
                    idx_d = start_index;
                    inc_d = (command_method_parameter == METHOD_INC);
                    dir_d = link.control_word[CW_DIR_BIT];
                    sum_d = '0;
                    state_d = S_FETCH;
                end
            end
            S_FETCH: state_d = S_LOAD;
            S_LOAD: begin
                last_d = entry_end || (idx_q == IDX_MAX);
                dw_d = table_dwell;
                if (entry_abs) begin
                    tgt_d = table_pos;
                    rev_d = $signed(table_pos) < $signed(current_pos);
                end else begin
                    // incremental entries add to the running travel
                    sum_d = sum_q + table_pos;
                    tgt_d = current_pos + table_pos;
                    rev_d = inc_q ? dir_q : 1'b0;
                end
                go_d = 1'b1;
                state_d = S_MOVE;
            end
            S_MOVE: begin
                if (motion_done && !go_q) begin
                    if (last_q) begin
                        done_d = 1'b1;
                        state_d = S_IDLE;
                    end else begin
                        dwell_d = dw_q;
                        cyc_d = '0;
                        state_d = S_DWELL;
                    end
                end
            end
            S_DWELL: begin
                if (dwell_q == '0) begin
                    idx_d = idx_q + IDX_MIN;
                    state_d = S_FETCH;
                end else if (cyc_q == CYC_W'(CYC_PER_MS - 1)) begin
                    cyc_d = '0;
                    dwell_d = dwell_q - 1'b1;
                end else begin
                    cyc_d = cyc_q + 1'b1;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            idx_q <= '0;
            tgt_q <= '0;
            sum_q <= '0;
            rev_q <= 1'b0;
            dir_q <= 1'b0;
            inc_q <= 1'b0;
            go_q <= 1'b0;
            last_q <= 1'b0;
            done_q <= 1'b0;
            dw_q <= '0;
            dwell_q <= '0;
            cyc_q <= '0;
            sp_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            idx_q <= idx_d;
            tgt_q <= tgt_d;
            sum_q <= sum_d;
            rev_q <= rev_d;
            dir_q <= dir_d;
            inc_q <= inc_d;
            go_q <= go_d;
            last_q <= last_d;
            done_q <= done_d;
            dw_q <= dw_d;
            dwell_q <= dwell_d;
            cyc_q <= cyc_d;
            sp_q <= link.control_word[CW_SETPOINT_BIT];
        end
    end

    assign table_index = idx_q;
    assign move_start = go_q;
    assign move_target = tgt_q;
    assign move_reverse = rev_q;
    assign travel_total = sum_q;
    assign link.servo_on = servo_ready;
    assign link.moving = !motion_done;
    assign link.busy = (state_q != S_IDLE);
    assign link.done = done_q;
    assign link.cur_index = idx_q;
endmodule : pt_device_end

/* core/pt_master_end.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// master side: raises set-point with direction set first
// ------------------------------------------------------------
module pt_master_end
    import pt_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    pt_link_if.master link,
    input wire logic start_req,
    input wire logic reverse_dir,
    output logic start_ack,
    output logic seq_done
);
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_DIR = 2'b01,
        M_SET = 2'b10
    } mst_state_t;

    mst_state_t state_q, state_d;
    logic dir_q, dir_d;
    logic set_q, set_d;

    always_comb begin
        state_d = state_q;
        dir_d = dir_q;
        set_d = set_q;
        case (state_q)
            M_IDLE: begin
                set_d = 1'b0;
                if (start_req && !link.moving && link.servo_on &&
                    !link.busy) begin
                    dir_d = reverse_dir;
                    state_d = M_DIR;
                end
            end
            // direction stands one cycle before the set-point edge
            M_DIR: begin
                set_d = 1'b1;
                state_d = M_SET;
            end
            M_SET: begin
                if (link.busy || link.done) begin
                    set_d = 1'b0;
                    state_d = M_IDLE;
                end else if (link.moving || !link.servo_on) begin
                    // refused start: drop it so the next rise is seen
                    set_d = 1'b0;
                    state_d = M_IDLE;
                end
            end
            default: state_d = M_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= M_IDLE;
            dir_q <= 1'b0;
            set_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            dir_q <= dir_d;
            set_q <= set_d;
        end
    end

    always_comb begin
        link.control_word = 16'h0000;
        link.control_word[CW_SETPOINT_BIT] = set_q;
        link.control_word[CW_DIR_BIT] = dir_q;
    end
    assign start_ack = (state_q == M_SET) && (link.busy || link.done);
    assign seq_done = link.done;
endmodule : pt_master_end

/* inc/pt_link_if.sv */
`timescale 1ns/1ps
interface pt_link_if;
    import pt_seq_pkg::*;
    logic [15:0] control_word;
    logic servo_on;
    logic moving;
    logic busy;
    logic done;
    logic [IDX_W-1:0] cur_index;

    modport device (
        input control_word,
        output servo_on,
        output moving,
        output busy,
        output done,
        output cur_index
    );
    modport master (
        output control_word,
        input servo_on,
        input moving,
        input busy,
        input done,
        input cur_index
    );
endinterface : pt_link_if

/* inc/pt_seq_pkg.sv */
package pt_seq_pkg;
    // ------------------------------------------------------------
    // control word and parameter fields
    // ------------------------------------------------------------
    localparam int CW_SETPOINT_BIT = 4;
    localparam int CW_DIR_BIT = 5;
    localparam logic [3:0] METHOD_ABS = 4'h0;
    localparam logic [3:0] METHOD_INC = 4'h1;
    // ------------------------------------------------------------
    // auxiliary function codes
    // ------------------------------------------------------------
    localparam logic [1:0] AUX_ABS_END = 2'h0;
    localparam logic [1:0] AUX_ABS_CHAIN = 2'h1;
    localparam logic [1:0] AUX_INC_END = 2'h2;
    localparam logic [1:0] AUX_INC_CHAIN = 2'h3;
    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int POS_W = 32;
    localparam int IDX_W = 8;
    localparam int DWELL_W = 16;
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_PER_S = 1000;
    localparam int DWELL_UNIT_MS = 1;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S * DWELL_UNIT_MS;
    localparam int CYC_W = 15;
    localparam logic [IDX_W-1:0] IDX_MAX = 8'hff;
    localparam logic [IDX_W-1:0] IDX_MIN = 8'h01;
    localparam logic [3:0] CW_RESET = 4'h0;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_FETCH = 3'b001,
        S_LOAD = 3'b010,
        S_MOVE = 3'b011,
        S_DWELL = 3'b100
    } seq_state_t;
endpackage : pt_seq_pkg

/* tb/point_table_sequencer_bench.sv */
`timescale 1ns/1ps
module point_table_sequencer_bench;
    import pt_seq_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic start_req = 0;
    logic rdir = 0;
    logic srv = 1;
    logic stall = 0;
    logic [3:0] meth = METHOD_ABS;
    logic [7:0] sidx = 8'h01;
    logic [31:0] pos = 0;
    logic [7:0] tix;
    logic mv, mrev, ack, sdone;
    logic [31:0] mtgt, ttot;
    logic [31:0] tpos [256];
    logic [15:0] tdw [256];
    logic [1:0] tax [256];
    logic [31:0] q_tgt [$];
    logic q_rev [$];
    int q_cyc [$];
    int cyc = 0;
    int mcnt = 0;
    int n_errors = 0;
    int check_count = 0;
    int t_done;
    pt_link_if link ();
    always #25 clk = ~clk;
    // ------------------------------------------
    // motor: five cycles per move, then settles
    // ------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mv) begin
            q_tgt.push_back(mtgt);
            q_rev.push_back(mrev);
            q_cyc.push_back(cyc);
            mcnt <= 5;
        end else if (mcnt > 0) begin
            mcnt <= mcnt - 1;
            if (mcnt == 1) pos <= mtgt;
        end
    end
    pt_master_end u_pt_master_end (.clk(clk), .rst_n(rst_n),
        .clk_en(1'b1), .link(link), .start_req(start_req),
        .reverse_dir(rdir), .start_ack(ack), .seq_done(sdone));
    pt_device_end u_pt_device_end (.clk(clk), .rst_n(rst_n),
        .clk_en(1'b1), .link(link), .command_method_parameter(meth),
        .servo_ready(srv), .start_index(sidx), .current_pos(pos),
        .motion_done(mcnt == 0 && !stall), .table_index(tix),
        .table_pos(tpos[tix]), .table_dwell(tdw[tix]),
        .table_aux(tax[tix]), .move_start(mv), .move_target(mtgt),
        .move_reverse(mrev), .travel_total(ttot));
    pt_link_monitor u_pt_link_monitor (.clk(clk), .rst_n(rst_n),
        .control_word(link.control_word), .servo_on(link.servo_on),
        .moving(link.moving), .busy(link.busy), .done(link.done),
        .cur_index(link.cur_index));
    // ------------------------------------------
    // tasks
    // ------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task conclude();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task ent(input int i, input logic [31:0] p, input logic [15:0] w,
        input logic [1:0] a);
        tpos[i] = p;
        tdw[i] = w;
        tax[i] = a;
    endtask : ent
    task mv_is(input int i, input logic [31:0] t, input logic r);
        check(q_tgt[i], t);
        check(q_rev[i], r);
    endtask : mv_is
    // outputs sampled at the falling edge, inputs moved at the rising one
    task run(input logic [3:0] m, input logic [7:0] ix, input logic d);
        int n;
        n = 0;
        q_tgt.delete();
        q_rev.delete();
        q_cyc.delete();
        meth <= m;
        sidx <= ix;
        rdir <= d;
        @(posedge clk);
        start_req <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        check(n < 50, 1'b1);
        @(posedge clk);
        start_req <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sdone !== 1'b1 && n < 30000);
        t_done = cyc;
        check(n < 30000, 1'b1);
        repeat (4) @(posedge clk);
    endtask : run
    initial begin
        ent(1, 32'h1f4, 16'h0, AUX_ABS_CHAIN);
        ent(2, 32'h1f4, 16'h0, AUX_INC_CHAIN);
        ent(3, 32'hc8, 16'h0, AUX_ABS_END);
        ent(4, 32'h64, 16'h0, AUX_INC_CHAIN);
        ent(5, 32'h32, 16'h0, AUX_INC_END);
        ent(6, 32'h7, 16'h0, AUX_ABS_CHAIN);
        ent(10, 32'h5, 16'h0, 2'h1);
        ent(11, 32'h6, 16'h1, 2'h1);
        ent(12, 32'h3, 16'h1, 2'h0);
        ent(13, 32'h9, 16'h0, 2'h1);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // motor starts turning, then servo drops, after the request
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            start_req <= 1'b1;
            @(posedge clk);
            if (k == 0) stall <= 1'b1;
            else srv <= 1'b0;
            repeat (20) @(posedge clk);
            @(negedge clk);
            check(link.busy, 1'b0);
            check(q_tgt.size(), 0);
            @(posedge clk);
            start_req <= 1'b0;
            stall <= 1'b0;
            srv <= 1'b1;
            repeat (5) @(posedge clk);
        end
        run(METHOD_ABS, 8'h01, 1'b0);
        check(q_tgt.size(), 3);
        mv_is(0, 32'h1f4, 1'b0);
        mv_is(1, 32'h3e8, 1'b0);
        mv_is(2, 32'hc8, 1'b1);
        check(ttot, 32'h1f4);
        run(METHOD_ABS, 8'h04, 1'b0);
        check(q_tgt.size(), 2);
        mv_is(0, 32'h12c, 1'b0);
        mv_is(1, 32'h15e, 1'b0);
        check(ttot, 32'h96);
        run(METHOD_INC, 8'h0a, 1'b0);
        check(q_tgt.size(), 3);
        mv_is(0, 32'h163, 1'b0);
        mv_is(2, 32'h16c, 1'b0);
        check(ttot, 32'he);
        check(q_cyc[2] - q_cyc[1] > CYC_PER_MS, 1'b1);
        check(t_done - q_cyc[2] < 100, 1'b1);
        run(METHOD_INC, 8'h0a, 1'b1);
        check(q_rev[0], 1'b1);
        check(q_rev[2], 1'b1);
        conclude();
    end
    initial begin
        #(50 * 100000);
        n_errors++;
        conclude();
    end
endmodule : point_table_sequencer_bench

/* tb/pt_link_monitor.sv */
`timescale 1ns/1ps
// ------------------------------------------
// link checker
// ------------------------------------------
module pt_link_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] control_word,
    input wire logic servo_on,
    input wire logic moving,
    input wire logic busy,
    input wire logic done,
    input wire logic [7:0] cur_index
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire sp = control_word[4];

    a_start_taken: assert property ($rose(sp) && !busy && servo_on
        && !moving |=> busy) else $error("start lost");
    a_turning_refused: assert property ($rose(sp) && !busy
        && moving |=> !busy) else $error("start while turning");
    a_servo_refused: assert property ($rose(sp) && !busy
        && !servo_on |=> !busy) else $error("start with servo off");
    a_dir_first: assert property ($rose(sp)
        |-> $stable(control_word[5])) else $error("direction late");
    a_done_pulse: assert property (done |=> !done)
        else $error("done too long");
    a_idle_via_done: assert property ($fell(busy)
        |-> done || $past(done)) else $error("end without done");
    a_done_in_run: assert property (done
        |-> busy || $past(busy)) else $error("stray done");
    // loads of the first entry are excluded by the idle history
    a_index_step: assert property ($changed(cur_index)
        && $past(busy) && $past(busy, 2) && $past(busy, 3)
        |-> cur_index == $past(cur_index) + 8'h01)
        else $error("entry skipped");
endmodule : pt_link_monitor
